// >>> core/tla_core.sv
// Purpose: modified two-bit lag autocorrelator with state counters and byte readout
// Assumes: frame tick is a one-cycle pulse shared with the total-power channel
// Notes:   word 0..128 are lags 0..128, words 129..132 the state counters
`timescale 1ns/100ps
module tla_core
  import tla_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       sample_sign,
  input  wire logic       sample_mag,
  input  wire logic       instrument_minor_frame,
  input  wire logic       count_enable,
  input  wire logic       count_clear,
  input  wire logic       rd_restart,
  input  wire logic       rd_strobe,
  output logic      [7:0] rd_data,
  output logic            rd_valid,
  output logic            snap_ready
);
  logic         rst_s0_reg;
  logic         rst_n_s;
  tla_core_st_t core_reg;
  tla_core_st_t core_next;

  logic [NUM_LAGS-1:0][2:0]        prod_w;
  logic [NUM_LAGS-1:0][ACC_W-1:0]  acc_w;
  logic [NUM_WORDS-1:0][ACC_W-1:0] snap_w;
  logic                            lane_clear;
  logic                            lane_add;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s0_reg <= 1'b0;
      rst_n_s    <= 1'b0;
    end else begin
      rst_s0_reg <= 1'b1;
      rst_n_s    <= rst_s0_reg;
    end
  end

  // integration restarts on the frame tick; the tick cycle adds nothing
  assign lane_clear = instrument_minor_frame | count_clear;
  assign lane_add   = count_enable;

  genvar k;
  generate
    for (k = 0; k < NUM_LAGS; k++) begin : g_lag
      assign prod_w[k] = tla_product(core_reg.dl[0], core_reg.dl[k]);
      tla_lane u_lane (
        .clk    (ref_clk),
        .rst_n  (rst_n_s),
        .clear  (lane_clear),
        .add_en (lane_add),
        .prod   (prod_w[k]),
        .acc    (acc_w[k])
      );
      assign snap_w[k] = acc_w[k];
    end
    for (k = 0; k < NUM_STATES; k++) begin : g_st
      assign snap_w[STATE_WORD_BASE + k] = core_reg.st_cnt[k];
    end
  endgenerate

  always_comb begin
    core_next = core_reg;
    core_next.dl[0] = {sample_sign, sample_mag};
    for (int i = 1; i < NUM_LAGS; i++) begin
      core_next.dl[i] = core_reg.dl[i - TAP_STEP_CYC];
    end
    if (lane_clear) begin
      core_next.st_cnt = '0;
    end else if (count_enable) begin
      core_next.st_cnt[tla_state_idx(core_reg.dl[0])] =
        core_reg.st_cnt[tla_state_idx(core_reg.dl[0])] + 24'h000001;
    end
    if (instrument_minor_frame) begin
      core_next.snap_ready = 1'b1;
    end
    core_next.rd_valid = rd_strobe;
    if (instrument_minor_frame || rd_restart) begin
      core_next.rd_word = WORD_RST;
      core_next.rd_byte = BYTE_RST;
    end else if (rd_strobe) begin
      if (core_reg.rd_byte == BYTE_LAST) begin
        core_next.rd_byte = BYTE_RST;
        core_next.rd_word = (core_reg.rd_word == WORD_LAST) ? WORD_RST
                                                            : core_reg.rd_word + 8'h01;
      end else begin
        core_next.rd_byte = core_reg.rd_byte + 2'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      core_reg <= '0;
    end else begin
      core_reg <= core_next;
    end
  end

  // frozen copy taken from the counts just before they clear
  tla_snap_mem u_snap (
    .clk   (ref_clk),
    .rst_n (rst_n_s),
    .wr    (instrument_minor_frame),
    .wdata (snap_w),
    .raddr (core_reg.rd_word),
    .rbyte (core_reg.rd_byte),
    .rdata (rd_data)
  );

  assign rd_valid   = core_reg.rd_valid;
  assign snap_ready = core_reg.snap_ready;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n_s);

  logic [ACC_W+1:0] st_sum;
  assign st_sum = {2'b00, core_reg.st_cnt[0]} + {2'b00, core_reg.st_cnt[1]}
                + {2'b00, core_reg.st_cnt[2]} + {2'b00, core_reg.st_cnt[3]};

  property p_take_sample;
    ##1 core_reg.dl[0] == $past({sample_sign, sample_mag});
  endproperty
  a_take_sample: assert property (p_take_sample) else $error("sample not taken");

  property p_tap_step;
    ##1 core_reg.dl[6] == $past(core_reg.dl[5]);
  endproperty
  a_tap_step: assert property (p_tap_step) else $error("tap step wrong");

  property p_depth;
    ##128 core_reg.dl[128] == $past(core_reg.dl[0], 128);
  endproperty
  a_depth: assert property (p_depth) else $error("delay depth wrong");

  property p_low_low;
    (!core_reg.dl[0][MAG_BIT] && !core_reg.dl[3][MAG_BIT]) |-> prod_w[3] == 3'h3;
  endproperty
  a_low_low: assert property (p_low_low) else $error("low pair not 3");

  property p_high_high;
    (core_reg.dl[0] == ST_HIGH_POS && core_reg.dl[2] == ST_HIGH_NEG) |-> prod_w[2] == 3'h0;
  endproperty
  a_high_high: assert property (p_high_high) else $error("opposite high not 0");

  property p_high_low;
    (core_reg.dl[0] == ST_HIGH_NEG && core_reg.dl[4] == ST_LOW_NEG) |-> prod_w[4] == 3'h4;
  endproperty
  a_high_low: assert property (p_high_low) else $error("same sign mixed not 4");

  property p_count_up;
    (!lane_clear && lane_add) |=> acc_w[1] == $past(acc_w[1]) + {21'h0, $past(prod_w[1])};
  endproperty
  a_count_up: assert property (p_count_up) else $error("lag did not add product");

  property p_state_tally;
    (!lane_clear && count_enable) |=> st_sum == $past(st_sum) + 26'h0000001;
  endproperty
  a_state_tally: assert property (p_state_tally) else $error("state tally wrong");

  property p_start_clear;
    instrument_minor_frame |=> (acc_w[0] == ACC_RST && st_sum == 26'h0);
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("not cleared at start");

  property p_read_pulse;
    rd_strobe |=> rd_valid ##1 (rd_valid == $past(rd_strobe));
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read valid misaligned");

  // independent copy of the product table for lag 1, undelayed sample first
  logic [2:0] ref_prod;
  always_comb begin
    ref_prod = 3'h3;
    unique case ({core_reg.dl[0], core_reg.dl[1]})
      {ST_HIGH_POS, ST_HIGH_NEG}: ref_prod = 3'h0;
      {ST_HIGH_POS, ST_LOW_NEG}:  ref_prod = 3'h2;
      {ST_HIGH_POS, ST_LOW_POS}:  ref_prod = 3'h4;
      {ST_HIGH_POS, ST_HIGH_POS}: ref_prod = 3'h6;
      {ST_LOW_POS, ST_HIGH_NEG}:  ref_prod = 3'h2;
      {ST_LOW_POS, ST_LOW_NEG}:   ref_prod = 3'h3;
      {ST_LOW_POS, ST_LOW_POS}:   ref_prod = 3'h3;
      {ST_LOW_POS, ST_HIGH_POS}:  ref_prod = 3'h4;
      {ST_LOW_NEG, ST_HIGH_NEG}:  ref_prod = 3'h4;
      {ST_LOW_NEG, ST_LOW_NEG}:   ref_prod = 3'h3;
      {ST_LOW_NEG, ST_LOW_POS}:   ref_prod = 3'h3;
      {ST_LOW_NEG, ST_HIGH_POS}:  ref_prod = 3'h2;
      {ST_HIGH_NEG, ST_HIGH_NEG}: ref_prod = 3'h6;
      {ST_HIGH_NEG, ST_LOW_NEG}:  ref_prod = 3'h4;
      {ST_HIGH_NEG, ST_LOW_POS}:  ref_prod = 3'h2;
      {ST_HIGH_NEG, ST_HIGH_POS}: ref_prod = 3'h0;
    endcase
  end

  property p_table;
    prod_w[1] == ref_prod;
  endproperty
  a_table: assert property (p_table) else $error("product table wrong");

  // lag 0 holds 3 per sample plus 3 more per outer-threshold sample
  logic [ACC_W-1:0] lag0_ref;
  assign lag0_ref = st_sum[ACC_W-1:0] * 24'h000003
                  + (core_reg.st_cnt[0] + core_reg.st_cnt[3]) * 24'h000003;

  property p_offset;
    acc_w[0] == lag0_ref;
  endproperty
  a_offset: assert property (p_offset) else $error("lag offset not 3 per sample");

  property p_hold_off;
    (!lane_clear && !count_enable) |=>
      (acc_w[64] == $past(acc_w[64]) && st_sum == $past(st_sum));
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("counted while disabled");

  property p_clear;
    count_clear |=> (acc_w[128] == ACC_RST && st_sum == 26'h0000000);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero");

  property p_frame_sync;
    instrument_minor_frame |=> (acc_w[128] == ACC_RST && core_reg.st_cnt[0] == ACC_RST);
  endproperty
  a_frame_sync: assert property (p_frame_sync) else $error("windows not in step");

  property p_snap_take;
    instrument_minor_frame |=> u_snap.mem_reg.mem[1] == $past(acc_w[1]);
  endproperty
  a_snap_take: assert property (p_snap_take) else $error("frozen copy not taken");

  property p_snap_hold;
    !instrument_minor_frame |=> $stable(u_snap.mem_reg.mem[0]);
  endproperty
  a_snap_hold: assert property (p_snap_hold) else $error("frozen copy changed");

  property p_ready;
    instrument_minor_frame |=> snap_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not set");

  property p_slot_hp;
    (!lane_clear && count_enable && core_reg.dl[0] == ST_HIGH_POS) |=>
      core_reg.st_cnt[3] == $past(core_reg.st_cnt[3]) + 24'h000001;
  endproperty
  a_slot_hp: assert property (p_slot_hp) else $error("high pos slot wrong");

  property p_slot_ln;
    (!lane_clear && count_enable && core_reg.dl[0] == ST_LOW_NEG) |=>
      core_reg.st_cnt[1] == $past(core_reg.st_cnt[1]) + 24'h000001;
  endproperty
  a_slot_ln: assert property (p_slot_ln) else $error("low neg slot wrong");

  property p_restart;
    rd_restart |=> (core_reg.rd_word == WORD_RST && core_reg.rd_byte == BYTE_RST);
  endproperty
  a_restart: assert property (p_restart) else $error("restart missed");

  property p_rd_wrap;
    (rd_strobe && !rd_restart && !instrument_minor_frame &&
     core_reg.rd_word == WORD_LAST && core_reg.rd_byte == BYTE_LAST) |=>
      (core_reg.rd_word == WORD_RST && core_reg.rd_byte == BYTE_RST);
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("pointer did not wrap");

  property p_rd_byte;
    (rd_strobe && core_reg.rd_word == 8'h01 && core_reg.rd_byte == BYTE_RST) |=>
      rd_data == $past(u_snap.mem_reg.mem[1][7:0]);
  endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("read byte wrong");

  property p_tap_far;
    ##1 core_reg.dl[100] == $past(core_reg.dl[99]);
  endproperty
  a_tap_far: assert property (p_tap_far) else $error("far tap step wrong");

  property p_high_same;
    (core_reg.dl[0] == ST_HIGH_NEG && core_reg.dl[2] == ST_HIGH_NEG) |-> prod_w[2] == 3'h6;
  endproperty
  a_high_same: assert property (p_high_same) else $error("same high not 6");

  property p_mixed_opp;
    (core_reg.dl[0] == ST_LOW_POS && core_reg.dl[1] == ST_HIGH_NEG) |-> prod_w[1] == 3'h2;
  endproperty
  a_mixed_opp: assert property (p_mixed_opp) else $error("opposite mixed not 2");

  c_frame:   cover property (instrument_minor_frame ##[1:250] instrument_minor_frame);
  c_read:    cover property (snap_ready && rd_strobe ##1 rd_valid);
  c_hh_same: cover property (prod_w[0] == PROD_HH_SAME);
  c_idle:    cover property (!count_enable && instrument_minor_frame);
  c_wrap:    cover property (rd_strobe && core_reg.rd_word == WORD_LAST);
endmodule

// >>> core/tla_pkg.sv
// Purpose: shared constants, types and helpers of the two-bit lag autocorrelator
// Assumes: 25 MHz sample clock, one 2-bit sign/magnitude sample per clock
// Notes:   state codes are {sign, magnitude}; sign 1 is negative, magnitude 1 is outer
package tla_pkg;

  localparam int unsigned CLK_MHZ         = 25;
  localparam int unsigned CLK_PERIOD_NS   = 1000 / CLK_MHZ;
  localparam int unsigned TAP_STEP_NS     = 40;
  localparam int unsigned TAP_STEP_CYC    = (TAP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BLANK_MS        = 5;

  localparam int unsigned DELAY_DEPTH     = 128;
  localparam int unsigned NUM_LAGS        = DELAY_DEPTH + 1;
  localparam int unsigned NUM_STATES      = 4;
  localparam int unsigned ACC_W           = 24;
  localparam int unsigned NUM_WORDS       = NUM_LAGS + NUM_STATES;
  localparam int unsigned BYTES_PER_WORD  = 3;
  localparam int unsigned WORD_IDX_W      = 8;
  localparam int unsigned STATE_WORD_BASE = NUM_LAGS;

  localparam logic [1:0] ST_HIGH_NEG = 2'h3;
  localparam logic [1:0] ST_LOW_NEG  = 2'h2;
  localparam logic [1:0] ST_LOW_POS  = 2'h0;
  localparam logic [1:0] ST_HIGH_POS = 2'h1;
  localparam int unsigned SIGN_BIT   = 1;
  localparam int unsigned MAG_BIT    = 0;

  localparam logic [2:0] PROD_HH_SAME  = 3'h6;
  localparam logic [2:0] PROD_HL_SAME  = 3'h4;
  localparam logic [2:0] PROD_ZERO     = 3'h3;
  localparam logic [2:0] PROD_HL_OPP   = 3'h2;
  localparam logic [2:0] PROD_HH_OPP   = 3'h0;

  localparam logic [ACC_W-1:0]      ACC_RST  = 24'h000000;
  localparam logic [WORD_IDX_W-1:0] WORD_RST = 8'h00;
  localparam logic [1:0]            BYTE_RST = 2'h0;
  localparam logic [1:0]            BYTE_LAST = 2'h2;
  localparam logic [WORD_IDX_W-1:0] WORD_LAST = 8'h84;

  typedef struct packed {
    logic [ACC_W-1:0] acc;
  } tla_lane_st_t;

  typedef struct packed {
    logic [NUM_WORDS-1:0][ACC_W-1:0] mem;
    logic [7:0]                      rdata;
  } tla_mem_st_t;

  typedef struct packed {
    logic [NUM_LAGS-1:0][1:0]          dl;
    logic [NUM_STATES-1:0][ACC_W-1:0]  st_cnt;
    logic [WORD_IDX_W-1:0]             rd_word;
    logic [1:0]                        rd_byte;
    logic                              rd_valid;
    logic                              snap_ready;
  } tla_core_st_t;

  // offset product of undelayed and delayed sample, range 0..6
  function automatic logic [2:0] tla_product(input logic [1:0] und, input logic [1:0] dly);
    logic same;
    same = (und[SIGN_BIT] == dly[SIGN_BIT]);
    if (!und[MAG_BIT] && !dly[MAG_BIT]) begin
      return PROD_ZERO;
    end else if (und[MAG_BIT] && dly[MAG_BIT]) begin
      return same ? PROD_HH_SAME : PROD_HH_OPP;
    end else begin
      return same ? PROD_HL_SAME : PROD_HL_OPP;
    end
  endfunction

  // counter slot order: high neg, low neg, low pos, high pos
  function automatic logic [1:0] tla_state_idx(input logic [1:0] s);
    logic [1:0] idx;
    idx = 2'h0;
    unique case (s)
      ST_HIGH_NEG: idx = 2'h0;
      ST_LOW_NEG:  idx = 2'h1;
      ST_LOW_POS:  idx = 2'h2;
      ST_HIGH_POS: idx = 2'h3;
    endcase
    return idx;
  endfunction

endpackage

// >>> core/tla_lane.sv
// Purpose: one count-up lag accumulator
// Assumes: product is already offset to be non-negative
// Notes:   clear has priority over adding
`timescale 1ns/100ps
module tla_lane
  import tla_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      clear,
  input  wire logic                      add_en,
  input  wire logic [2:0]                prod,
  output logic      [tla_pkg::ACC_W-1:0] acc
);
  tla_lane_st_t lane_reg;
  tla_lane_st_t lane_next;

  always_comb begin
    lane_next = lane_reg;
    if (clear) begin
      lane_next.acc = ACC_RST;
    end else if (add_en) begin
      lane_next.acc = lane_reg.acc + {{(ACC_W-3){1'b0}}, prod};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_reg <= '0;
    end else begin
      lane_reg <= lane_next;
    end
  end

  assign acc = lane_reg.acc;
endmodule

// >>> core/tla_snap_mem.sv
// Purpose: frozen copy of all counters, read out one byte at a time
// Assumes: whole array is written in one cycle at integration end
// Notes:   read byte appears one cycle after the address; bytes low first
`timescale 1ns/100ps
module tla_snap_mem
  import tla_pkg::*;
(
  input  wire logic                                             clk,
  input  wire logic                                             rst_n,
  input  wire logic                                             wr,
  input  wire logic [tla_pkg::NUM_WORDS-1:0][tla_pkg::ACC_W-1:0] wdata,
  input  wire logic [tla_pkg::WORD_IDX_W-1:0]                   raddr,
  input  wire logic [1:0]                                       rbyte,
  output logic      [7:0]                                       rdata
);
  tla_mem_st_t mem_reg;
  tla_mem_st_t mem_next;

  always_comb begin
    mem_next = mem_reg;
    if (wr) begin
      mem_next.mem = wdata;
    end
    if (raddr <= WORD_LAST && rbyte <= BYTE_LAST) begin
      mem_next.rdata = mem_reg.mem[raddr][rbyte*8 +: 8];
    end else begin
      mem_next.rdata = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_reg <= '0;
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign rdata = mem_reg.rdata;
endmodule

// >>> dv/tla_far_model.sv
// Purpose: far side of the autocorrelator: digitizer and byte readout unit
// Assumes: readout starts only when no frame tick is due
// Notes:   digitizer alternates two states so odd and even lags differ
`timescale 1ns/100ps
module tla_far_model
  import tla_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  output logic            sample_sign,
  output logic            sample_mag,
  output logic            rd_restart,
  output logic            rd_strobe
);
  logic [1:0] code_a;
  logic [1:0] code_b;
  logic       phase;
  logic [7:0] bytes_q[$];

  initial begin
    code_a = 2'h0;
    code_b = 2'h0;
    phase = 1'b0;
    sample_sign = 1'b0;
    sample_mag = 1'b0;
    rd_restart = 1'b0;
    rd_strobe = 1'b0;
  end

  // one new {sign, magnitude} state each sample
  always @(posedge ref_clk) begin
    #1;
    phase = !phase;
    {sample_sign, sample_mag} = phase ? code_b : code_a;
  end

  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1) bytes_q.push_back(rd_data);
  end

  // rewind, then strobe every byte back to back, low byte first
  task automatic read_all(output logic [ACC_W-1:0] w [NUM_WORDS]);
    @(posedge ref_clk);
    #1 rd_restart = 1'b1;
    @(posedge ref_clk);
    #1 rd_restart = 1'b0;
    bytes_q.delete();
    rd_strobe = 1'b1;
    repeat (NUM_WORDS * BYTES_PER_WORD) @(posedge ref_clk);
    #1 rd_strobe = 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < NUM_WORDS; i++) begin
      w[i] = {bytes_q[3*i+2], bytes_q[3*i+1], bytes_q[3*i]};
    end
  endtask
endmodule

// >>> dv/two_bit_lag_autocorrelator_bench.sv
// Purpose: self-checking bench of the lag autocorrelator core
// Assumes: 25 MHz clock, far side played by tla_far_model
// Notes:   each integration spans 200 samples of a two-state pattern, counted when enabled and not cleared
`timescale 1ns/100ps
module two_bit_lag_autocorrelator_bench;
  import tla_pkg::*;
  logic             ref_clk;
  logic             rstn;
  logic             instrument_minor_frame;
  logic             count_enable;
  logic             count_clear;
  logic             sample_sign;
  logic             sample_mag;
  logic             rd_restart;
  logic             rd_strobe;
  logic [7:0]       rd_data;
  logic             rd_valid;
  logic             snap_ready;
  logic [ACC_W-1:0] words [NUM_WORDS];
  int               fails;
  int               check_count;

  tla_core dut_u (.ref_clk(ref_clk), .rstn(rstn), .sample_sign(sample_sign),
    .sample_mag(sample_mag), .instrument_minor_frame(instrument_minor_frame),
    .count_enable(count_enable), .count_clear(count_clear), .rd_restart(rd_restart),
    .rd_strobe(rd_strobe), .rd_data(rd_data), .rd_valid(rd_valid), .snap_ready(snap_ready));

  tla_far_model far_u (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .sample_sign(sample_sign), .sample_mag(sample_mag), .rd_restart(rd_restart),
    .rd_strobe(rd_strobe));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end

  task automatic final_report();
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [ACC_W-1:0] seen, input logic [ACC_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // expected offset product; rows undelayed, columns delayed: HN, LN, LP, HP
  function automatic int pr(input logic [1:0] u, input logic [1:0] d);
    logic [63:0] tbl;
    int          ui;
    int          di;
    tbl = 64'h6420_4332_2334_0246;
    ui = (u == ST_HIGH_NEG) ? 0 : (u == ST_LOW_NEG) ? 1 : (u == ST_LOW_POS) ? 2 : 3;
    di = (d == ST_HIGH_NEG) ? 0 : (d == ST_LOW_NEG) ? 1 : (d == ST_LOW_POS) ? 2 : 3;
    return int'(tbl[63-4*(ui*4+di) -: 4]);
  endfunction

  task automatic pulse_tick();
    #1 instrument_minor_frame = 1'b1;
    @(posedge ref_clk);
    #1 instrument_minor_frame = 1'b0;
  endtask

  // fill delay line with pattern a,b; integrate 200 samples; read frozen counts
  task automatic integrate(input logic [1:0] a, input logic [1:0] b, input logic en,
                           input logic clr);
    logic [1:0]       slot_code [4];
    logic [ACC_W-1:0] exp;
    int               t;
    slot_code = '{ST_HIGH_NEG, ST_LOW_NEG, ST_LOW_POS, ST_HIGH_POS};
    t = 0;
    @(negedge ref_clk);
    far_u.code_a = a;
    far_u.code_b = b;
    @(posedge ref_clk);
    #1 count_enable = en;
    count_clear = clr;
    repeat (140) @(posedge ref_clk);
    pulse_tick();
    repeat (200) @(posedge ref_clk);
    pulse_tick();
    far_u.read_all(words);
    for (int k = 0; k < NUM_LAGS; k++) begin
      exp = (k % 2) ? ACC_W'(200 * pr(a, b)) : ACC_W'(100 * (pr(a, a) + pr(b, b)));
      if (!en || clr) exp = '0;
      check(words[k], exp);
    end
    for (int i = 0; i < NUM_STATES; i++) begin
      exp = ACC_W'((slot_code[i] == a ? 100 : 0) + (slot_code[i] == b ? 100 : 0));
      if (!en || clr) exp = '0;
      check(words[STATE_WORD_BASE+i], exp);
      t += int'(words[STATE_WORD_BASE+i]);
    end
    check(ACC_W'(t), (!en || clr) ? '0 : ACC_W'(200));
    exp = ACC_W'(100 * (pr(a, a) + pr(b, b)) - 600);
    if (en && !clr) check(words[2] - ACC_W'(3 * t), exp);
    check(ACC_W'(snap_ready), ACC_W'(1));
  endtask

  initial begin
    fails = 0;
    check_count = 0;
    rstn = 1'b0;
    instrument_minor_frame = 1'b0;
    count_enable = 1'b0;
    count_clear = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    check(ACC_W'(snap_ready), ACC_W'(0));
    repeat (3) @(posedge ref_clk);
    for (int a = 0; a < 4; a++) begin
      for (int b = a + 1; b < 4; b++) begin
        integrate(2'(a), 2'(b), 1'b1, 1'b0);
      end
    end
    integrate(ST_HIGH_NEG, ST_HIGH_POS, 1'b0, 1'b0);
    integrate(ST_LOW_NEG, ST_HIGH_POS, 1'b1, 1'b1);
    integrate(ST_HIGH_POS, ST_LOW_POS, 1'b1, 1'b0);
    final_report();
  end

  initial begin
    #(40 * 20000);
    fails++;
    final_report();
  end
endmodule
